// *** rtl/fsrm_map.vh ***
// Constants for the floppy status, reset and mode block.
// Included by rtl/fsrm_top.v; definitions only.
`ifndef FSRM_MAP_VH
`define FSRM_MAP_VH
// Result status byte one fields
`define FSRM_S1_END_CYL 7
`define FSRM_S1_CRC_ANY 5
`define FSRM_S1_OVERRUN 4
`define FSRM_S1_NO_SECTOR 2
`define FSRM_S1_WR_BLOCK 1
`define FSRM_S1_ID_SYNC 0
// Result status byte two fields
`define FSRM_S2_CTRL_MARK 6
`define FSRM_S2_CRC_PAY 5
`define FSRM_S2_TRK_MIS 4
`define FSRM_S2_TRK_BAD 1
`define FSRM_S2_PAY_SYNC 0
// Result status byte three fields
`define FSRM_S3_WP 6
`define FSRM_S3_ONE_HI 5
`define FSRM_S3_OUTER_TRACK_PIN 4
`define FSRM_S3_ONE_LO 3
`define FSRM_S3_SIDE 2
// Values
`define FSRM_BYTE_ZERO 8'h00
`define FSRM_BAD_TRACK 8'hff
`define FSRM_LAST_SECTOR 8'hff
// Mode encodings
`define FSRM_MODE_FIRST 2'h0
`define FSRM_MODE_SECOND 2'h1
`define FSRM_MODE_THIRD 2'h2
// Config bit positions
`define FSRM_CFG_IDENT 3
`define FSRM_CFG_MODEL 2
// Configure byte bit that turns drive polling off
`define FSRM_CFG_POLL_OFF 4
// Read masks keep unused status bits at zero
`define FSRM_S1_MASK 8'hb7
`define FSRM_S2_MASK 8'h73
// Result byte selects
`define FSRM_SEL_ONE 2'h1
`define FSRM_SEL_TWO 2'h2
`define FSRM_SEL_THREE 2'h3
// Self-clearing reset hold, in cycles
`define FSRM_SOFT_HOLD 8'h10
`endif

// *** rtl/fsrm_top.v ***
// Status bytes, reset sources and operating mode of the floppy core.
// Assumes a command sequencer outside that pulses outcome events and
// strobes clear_status at command start; drive pins are asynchronous.
//
// Overview of operation
// - Byte one bit 7 set on access past last sector or missing end count.
// - Byte one bit 5 set on CRC error in identifier or data field.
// - Byte one bit 4 set when transfer service arrives too late.
// - Byte one bit 2 set when sector not found, id unreadable, bad order.
// - Byte one bit 1 set when write-protect high during a write command.
// - Byte one bit 0 set when identifier or data address mark missing.
// - Unused bits of bytes one and two always read zero.
// - Byte two bit 6 set on data mark type opposite to the command.
// - Byte two bit 5 set on CRC error in the data field.
// - Byte two bit 4 set when identifier track differs from internal track.
// - Byte two bit 1 set when that differing track is all ones.
// - Byte two bit 0 set when no data or deleted data mark found.
// - Byte three shows write-protect, track zero, side and unit selects.
// - Byte three bits 5 and 3 read one, bit 7 reads zero.
// - Pin, power-on, output and rate register resets all reset, exit power-down.
// - Any reset aborts operations and returns the core to idle.
// - Leaving reset clears configure settings and enables drive polling.
// - Pin reset keeps specify settings and sets output-register reset bit.
// - Rate reset self-clears, output reset held by host and wins.
// - Config bit 3 high picks first mode; bit 3 low, bit 2 high second.
// - First mode honours DMA enable, count and density active high.
// - Second mode ignores DMA enable, count and density active low.
// - Third mode honours DMA enable, count high, density low.
// - Status bytes delivered as data bytes in the result phase.
`timescale 1ns/1ps
`default_nettype none
`include "fsrm_map.vh"

module fsrm_top #(
	parameter [7:0] SOFT_HOLD = `FSRM_SOFT_HOLD
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	// Host register controls
	input wire out_reg_reset_wr,
	input wire out_reg_reset_val,
	input wire rate_reg_reset_wr,
	input wire dma_enable_bit,
	input wire [7:0] logical_dev0_cfg_f0,
	input wire [7:0] specify_in,
	input wire specify_wr,
	input wire [7:0] configure_in,
	input wire configure_wr,
	input wire [1:0] result_sel,
	input wire result_rd,
	// Command outcome events from the sequencer
	input wire clear_status,
	input wire write_cmd_active,
	input wire [7:0] sector_number,
	input wire sector_access,
	input wire end_count_missing,
	input wire crc_id_error,
	input wire crc_data_error,
	input wire service_late,
	input wire sector_not_found,
	input wire id_read_failed,
	input wire track_order_bad,
	input wire id_mark_missing,
	input wire data_mark_missing,
	input wire mark_type_wrong,
	input wire id_track_valid,
	input wire [7:0] id_track,
	input wire [7:0] internal_track,
	input wire transfer_count_end,
	input wire density_high,
	input wire irq_req,
	input wire dma_req,
	// Drive pins and selects
	input wire write_protect_pin,
	input wire outer_track_pin,
	input wire side_select_pin,
	input wire [1:0] unit_select_pins,
	// Outputs
	output reg [7:0] result_data,
	output reg core_reset,
	output reg power_down_exit,
	output reg out_reg_reset_bit,
	output reg polling_enabled,
	output reg [7:0] specify_params,
	output reg [7:0] configure_params,
	output reg [1:0] op_mode,
	output reg term_count_active,
	output reg density_level_out,
	output reg floppy_irq_out,
	output reg floppy_irq_oe,
	output reg floppy_dma_request,
	output reg floppy_dma_oe
);

	localparam ST_IDLE = 2'b01;
	localparam ST_RESET = 2'b10;

	reg rst_m;
	reg rst_s;
	reg [4:0] pin_m;
	reg [4:0] pin_s;
	reg [7:0] result_status_one;
	reg [7:0] result_status_two;
	reg [7:0] hold_cnt;
	reg [1:0] state;
	reg [1:0] next_mode;
	wire soft_active;
	wire wp_s;
	wire outer_track_pin_s;
	wire side_s;
	wire [1:0] unit_s;
	wire [7:0] result_status_three;

	function [1:0] mode_of;
		input [7:0] cfg;
		begin
			if (cfg[`FSRM_CFG_IDENT])
				mode_of = `FSRM_MODE_FIRST;
			else if (cfg[`FSRM_CFG_MODEL])
				mode_of = `FSRM_MODE_SECOND;
			else
				mode_of = `FSRM_MODE_THIRD;
		end
	endfunction

	// Reset release through two flops
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_s <= rst_m;
		end
	end

	// Drive pins are asynchronous; two flops before use
	always @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			pin_m <= 5'h00;
			pin_s <= 5'h00;
		end else begin
			pin_m <= {write_protect_pin, outer_track_pin, side_select_pin, unit_select_pins};
			pin_s <= pin_m;
		end
	end
	assign wp_s = pin_s[4];
	assign outer_track_pin_s = pin_s[3];
	assign side_s = pin_s[2];
	assign unit_s = pin_s[1:0];

	// Output-register reset wins over the rate reset
	assign soft_active = out_reg_reset_bit | (hold_cnt != `FSRM_BYTE_ZERO);

	// Reset sources and core control
	always @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			out_reg_reset_bit <= 1'b1;
			hold_cnt <= `FSRM_BYTE_ZERO;
			state <= ST_RESET;
			core_reset <= 1'b1;
			power_down_exit <= 1'b1;
			polling_enabled <= 1'b0;
			configure_params <= `FSRM_BYTE_ZERO;
		end else begin
			if (out_reg_reset_wr)
				out_reg_reset_bit <= out_reg_reset_val;
			if (rate_reg_reset_wr)
				hold_cnt <= SOFT_HOLD;
			else if (hold_cnt != `FSRM_BYTE_ZERO)
				hold_cnt <= hold_cnt - 8'h01;
			power_down_exit <= soft_active;
			core_reset <= soft_active;
			case (state)
				ST_RESET: begin
					configure_params <= `FSRM_BYTE_ZERO;
					polling_enabled <= 1'b0;
					if (!soft_active) begin
						state <= ST_IDLE;
						polling_enabled <= 1'b1;
					end
				end
				ST_IDLE: begin
					if (soft_active) begin
						state <= ST_RESET;
						polling_enabled <= 1'b0;
					end else if (configure_wr) begin
						configure_params <= configure_in;
						polling_enabled <= ~configure_in[`FSRM_CFG_POLL_OFF];
					end
				end
				default: state <= ST_RESET;
			endcase
		end
	end

	// Specify settings have no reset and survive every reset
	always @(posedge sys_clk) begin
		if (specify_wr)
			specify_params <= specify_in;
	end

	// Sticky status; a same-cycle event beats the clear
	always @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			result_status_one <= `FSRM_BYTE_ZERO;
			result_status_two <= `FSRM_BYTE_ZERO;
		end else if (core_reset) begin
			result_status_one <= `FSRM_BYTE_ZERO;
			result_status_two <= `FSRM_BYTE_ZERO;
		end else begin
			if (clear_status) begin
				result_status_one <= `FSRM_BYTE_ZERO;
				result_status_two <= `FSRM_BYTE_ZERO;
			end
			if ((sector_access && sector_number == `FSRM_LAST_SECTOR) || end_count_missing)
				result_status_one[`FSRM_S1_END_CYL] <= 1'b1;
			if (crc_id_error || crc_data_error)
				result_status_one[`FSRM_S1_CRC_ANY] <= 1'b1;
			if (service_late)
				result_status_one[`FSRM_S1_OVERRUN] <= 1'b1;
			if (sector_not_found || id_read_failed || track_order_bad)
				result_status_one[`FSRM_S1_NO_SECTOR] <= 1'b1;
			if (wp_s && write_cmd_active)
				result_status_one[`FSRM_S1_WR_BLOCK] <= 1'b1;
			if (id_mark_missing || data_mark_missing)
				result_status_one[`FSRM_S1_ID_SYNC] <= 1'b1;
			if (mark_type_wrong)
				result_status_two[`FSRM_S2_CTRL_MARK] <= 1'b1;
			if (crc_data_error)
				result_status_two[`FSRM_S2_CRC_PAY] <= 1'b1;
			if (id_track_valid && id_track != internal_track) begin
				result_status_two[`FSRM_S2_TRK_MIS] <= 1'b1;
				if (id_track == `FSRM_BAD_TRACK)
					result_status_two[`FSRM_S2_TRK_BAD] <= 1'b1;
			end
			if (data_mark_missing)
				result_status_two[`FSRM_S2_PAY_SYNC] <= 1'b1;
		end
	end

	// Live drive state, fixed bits per layout
	assign result_status_three = {1'b0, wp_s, 1'b1, outer_track_pin_s, 1'b1, side_s, unit_s};

	// Result byte out to data register; unused bits masked
	always @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s)
			result_data <= `FSRM_BYTE_ZERO;
		else if (result_rd) begin
			case (result_sel)
				`FSRM_SEL_ONE: result_data <= result_status_one & `FSRM_S1_MASK;
				`FSRM_SEL_TWO: result_data <= result_status_two & `FSRM_S2_MASK;
				`FSRM_SEL_THREE: result_data <= result_status_three;
				default: result_data <= `FSRM_BYTE_ZERO;
			endcase
		end
	end

	always @* begin
		next_mode = mode_of(logical_dev0_cfg_f0);
	end

	// Mode-dependent polarity and drive of pins
	always @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			op_mode <= `FSRM_MODE_FIRST;
			term_count_active <= 1'b0;
			density_level_out <= 1'b1;
			floppy_irq_out <= 1'b0;
			floppy_irq_oe <= 1'b0;
			floppy_dma_request <= 1'b0;
			floppy_dma_oe <= 1'b0;
		end else begin
			op_mode <= next_mode;
			floppy_irq_out <= irq_req & ~core_reset;
			floppy_dma_request <= dma_req & ~core_reset;
			case (next_mode)
				`FSRM_MODE_FIRST: begin
					term_count_active <= transfer_count_end;
					density_level_out <= density_high;
					floppy_irq_oe <= dma_enable_bit;
					floppy_dma_oe <= dma_enable_bit;
				end
				`FSRM_MODE_SECOND: begin
					term_count_active <= ~transfer_count_end;
					density_level_out <= ~density_high;
					floppy_irq_oe <= 1'b1;
					floppy_dma_oe <= 1'b1;
				end
				default: begin
					term_count_active <= transfer_count_end;
					density_level_out <= ~density_high;
					floppy_irq_oe <= dma_enable_bit;
					floppy_dma_oe <= dma_enable_bit;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// *** dv/fsrm_props.sv ***
// Port checker for fsrm_top: status bytes, reset sources, mode polarity.
// Bound into fsrm_top; ports carry the top module's port names.
`timescale 1ns/1ps
`default_nettype none
module fsrm_props #(
	parameter [7:0] SOFT_HOLD = 8'h10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Host side
	input wire logic rate_reg_reset_wr,
	input wire logic dma_enable_bit,
	input wire logic [7:0] logical_dev0_cfg_f0,
	input wire logic [1:0] result_sel,
	input wire logic result_rd,
	input wire logic transfer_count_end,
	// Outputs
	input wire logic [7:0] result_data,
	input wire logic core_reset,
	input wire logic power_down_exit,
	input wire logic out_reg_reset_bit,
	input wire logic polling_enabled,
	input wire logic [1:0] op_mode,
	input wire logic term_count_active,
	input wire logic floppy_irq_oe
);
	localparam int HK = SOFT_HOLD - 1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Guard on core reset and a stable config: mode flops follow the config one cycle late
	sequence steady;
		!core_reset && $stable(logical_dev0_cfg_f0);
	endsequence
	AST_S3_FIXED: assert property (result_rd && result_sel == 2'h3 |=> result_data[7:0] ==? 8'b0?1?1???)
		else $error("byte three fixed bits wrong");
	AST_S1_ZERO: assert property (result_rd && result_sel == 2'h1 |=> (result_data & 8'h48) == 8'h00)
		else $error("byte one unused bits set");
	AST_S2_ZERO: assert property (result_rd && result_sel == 2'h2 |=> (result_data & 8'h8c) == 8'h00)
		else $error("byte two unused bits set");
	AST_MODE: assert property (steady |-> op_mode == (logical_dev0_cfg_f0[3] ? 2'h0 : (logical_dev0_cfg_f0[2] ? 2'h1 : 2'h2)))
		else $error("mode does not follow config");
	AST_TERM: assert property (steady ##0 $stable(transfer_count_end) |-> term_count_active == (transfer_count_end ^ (op_mode == 2'h1)))
		else $error("count end polarity wrong");
	AST_OE: assert property (steady ##0 $stable(dma_enable_bit) |-> floppy_irq_oe == (dma_enable_bit || op_mode == 2'h1))
		else $error("irq enable wrong for mode");
	AST_RATE: assert property (rate_reg_reset_wr && !out_reg_reset_bit && !core_reset |-> ##2 core_reset ##HK core_reset ##1 !core_reset)
		else $error("rate reset hold wrong");
	AST_OUT_WINS: assert property (out_reg_reset_bit |=> core_reset)
		else $error("output reset bit not holding core");
	AST_PDX: assert property (core_reset |-> power_down_exit)
		else $error("reset without power-down exit");
	AST_POLL: assert property ($fell(core_reset) |=> polling_enabled)
		else $error("polling not started after reset");
	COV_RATE: cover property (rate_reg_reset_wr && !core_reset);
	COV_SECOND: cover property (op_mode == 2'h1);
	COV_S3: cover property (result_rd && result_sel == 2'h3);
endmodule
bind fsrm_top fsrm_props #(.SOFT_HOLD(SOFT_HOLD)) u_props (.*);
`default_nettype wire

// *** dv/fsrm_drive_model.sv ***
// Drive-side model: write-protect and track-zero levels on the cable.
// Levels move off the controller clock, as a real drive's would.
`timescale 1ns/1ps
`default_nettype none
module fsrm_drive_model (
	// Requests from the bench
	input wire logic protect_req,
	input wire logic home_req,
	// Cable levels
	output logic write_protect_pin,
	output logic outer_track_pin
);
	// Skew keeps edges unrelated to sys_clk; levels start low, not unknown
	initial begin
		write_protect_pin = 1'b0;
		forever begin
			@(protect_req);
			write_protect_pin <= #37 protect_req;
		end
	end
	initial begin
		outer_track_pin = 1'b0;
		forever begin
			@(home_req);
			outer_track_pin <= #61 home_req;
		end
	end
endmodule
`default_nettype wire

// *** dv/fsrm_top_tb.sv ***
// Bench for fsrm_top: strobes, event pulses, result reads, modes, resets.
// Write-protect and track-zero pins come from fsrm_drive_model; other inputs change at rising edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module fsrm_top_tb;
	localparam [7:0] SOFT_HOLD = 8'h04;
	logic sys_clk = 0, rst_b = 0, out_reg_reset_wr = 0, out_reg_reset_val = 0, rate_reg_reset_wr = 0;
	logic dma_enable_bit = 0, specify_wr = 0, configure_wr = 0, result_rd = 0, clear_status = 0;
	logic write_cmd_active = 0, sector_access = 0, id_track_valid = 0, transfer_count_end = 1, density_high = 1;
	logic irq_req = 1, dma_req = 1, side_select_pin = 0, wp_req = 0, home_req = 0, write_protect_pin, outer_track_pin;
	logic end_count_missing, crc_id_error, crc_data_error, service_late, sector_not_found, id_read_failed;
	logic track_order_bad, id_mark_missing, data_mark_missing, mark_type_wrong;
	logic [1:0] result_sel = 0, unit_select_pins = 0, op_mode, em;
	logic [7:0] logical_dev0_cfg_f0 = 0, specify_in = 0, configure_in = 0, sector_number = 0, id_track = 0;
	logic [7:0] internal_track = 8'h03, result_data, specify_params, configure_params;
	logic core_reset, power_down_exit, out_reg_reset_bit, polling_enabled, term_count_active, density_level_out;
	logic floppy_irq_out, floppy_irq_oe, floppy_dma_request, floppy_dma_oe;
	logic [9:0] ev = 0;
	logic [7:0] e1 [10] = '{8'h80, 8'h20, 8'h20, 8'h10, 8'h04, 8'h04, 8'h04, 8'h01, 8'h01, 8'h00};
	logic [7:0] e2 [10] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h40};
	logic [7:0] tid [3] = '{8'h05, 8'hff, 8'h03};
	logic [7:0] tex [3] = '{8'h10, 8'h12, 8'h00};
	int failures = 0, samples_checked = 0, n;
	assign {mark_type_wrong, data_mark_missing, id_mark_missing, track_order_bad, id_read_failed,
		sector_not_found, service_late, crc_data_error, crc_id_error, end_count_missing} = ev;
	fsrm_top #(.SOFT_HOLD(SOFT_HOLD)) i_dut (.*);
	fsrm_drive_model i_drive (.protect_req(wp_req), .home_req(home_req), .write_protect_pin(write_protect_pin),
		.outer_track_pin(outer_track_pin));
	initial forever #50 sys_clk = ~sys_clk;
	task automatic tk(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [1:0] s, input logic [7:0] exp);
		@(posedge sys_clk);
		result_sel <= s;
		result_rd <= 1;
		@(posedge sys_clk);
		result_rd <= 0;
		#1 `CHK(result_data, exp)
	endtask
	task automatic wr_out(input logic v);
		@(posedge sys_clk);
		out_reg_reset_wr <= 1;
		out_reg_reset_val <= v;
		@(posedge sys_clk);
		out_reg_reset_wr <= 0;
		tk(3);
	endtask
	task automatic pulse_ev(input int i);
		@(posedge sys_clk);
		clear_status <= 1;
		@(posedge sys_clk);
		clear_status <= 0;
		ev <= 10'h001 << i;
		@(posedge sys_clk);
		ev <= 0;
	endtask
	task automatic report_and_stop;
		$display("checked=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_b <= 1;
		tk(3);
		`CHK(out_reg_reset_bit, 1'b1)
		`CHK(core_reset, 1'b1)
		`CHK(floppy_irq_out, 1'b0)
		`CHK(floppy_dma_request, 1'b0)
		wr_out(0);
		`CHK(floppy_dma_request, 1'b1)
		`CHK(power_down_exit, 1'b0)
		`CHK(polling_enabled, 1'b1)
		$display("test reset_exit done");
		for (int i = 0; i < 10; i++) begin
			pulse_ev(i);
			rd(2'h1, e1[i]);
			rd(2'h2, e2[i]);
		end
		pulse_ev(10);
		sector_number <= 8'hff;
		sector_access <= 1;
		@(posedge sys_clk);
		sector_access <= 0;
		rd(2'h1, 8'h80);
		for (int j = 0; j < 3; j++) begin
			pulse_ev(10);
			id_track <= tid[j];
			id_track_valid <= 1;
			@(posedge sys_clk);
			id_track_valid <= 0;
			rd(2'h2, tex[j]);
		end
		$display("test events done");
		pulse_ev(10);
		write_cmd_active <= 1;
		wp_req <= 1;
		side_select_pin <= 1;
		unit_select_pins <= 2'h2;
		tk(4);
		rd(2'h1, 8'h02);
		rd(2'h3, 8'h6e);
		@(posedge sys_clk);
		write_cmd_active <= 0;
		wp_req <= 0;
		home_req <= 1;
		side_select_pin <= 0;
		unit_select_pins <= 2'h1;
		tk(4);
		rd(2'h3, 8'h39);
		rd(2'h0, 8'h00);
		$display("test drive_status done");
		for (int m = 0; m < 4; m++) begin
			@(posedge sys_clk);
			logical_dev0_cfg_f0 <= 8'(m << 2);
			dma_enable_bit <= !m[0];
			em = m[1] ? 2'h0 : (m[0] ? 2'h1 : 2'h2);
			tk(3);
			`CHK(op_mode, em)
			`CHK(term_count_active, em != 2'h1)
			`CHK(density_level_out, em == 2'h0)
			`CHK(floppy_dma_oe, (em == 2'h1) || !m[0])
			`CHK(floppy_irq_oe, (em == 2'h1) || !m[0])
			`CHK(floppy_irq_out, 1'b1)
		end
		$display("test modes done");
		pulse_ev(2);
		rate_reg_reset_wr <= 1;
		@(posedge sys_clk);
		rate_reg_reset_wr <= 0;
		tk(3);
		`CHK(core_reset, 1'b1)
		`CHK(power_down_exit, 1'b1)
		for (n = 0; n < 40 && core_reset !== 1'b0; n++)
			tk(1);
		if (n == 40) begin
			failures++;
			report_and_stop();
		end
		rd(2'h1, 8'h00);
		wr_out(1);
		@(posedge sys_clk);
		rate_reg_reset_wr <= 1;
		@(posedge sys_clk);
		rate_reg_reset_wr <= 0;
		tk(SOFT_HOLD + 10);
		`CHK(core_reset, 1'b1)
		wr_out(0);
		`CHK(core_reset, 1'b0)
		$display("test soft_resets done");
		@(posedge sys_clk);
		configure_in <= 8'h10;
		configure_wr <= 1;
		specify_in <= 8'h5a;
		specify_wr <= 1;
		@(posedge sys_clk);
		configure_wr <= 0;
		specify_wr <= 0;
		tk(3);
		`CHK(polling_enabled, 1'b0)
		`CHK(configure_params, 8'h10)
		@(posedge sys_clk);
		rst_b <= 0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1;
		tk(3);
		`CHK(specify_params, 8'h5a)
		`CHK(configure_params, 8'h00)
		`CHK(out_reg_reset_bit, 1'b1)
		$display("test pin_reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
